// ===== cia_pkg.sv
// Purpose: shared constants and types for the interrupt acknowledge block
// Assumes: 8-bit core, 24 maskable sources, 25 MHz cpu clock
// Notes:   bit numbers in the status word are placed by the core integration
package cia_pkg;
	localparam int           CIA_SRC_N      = 24;       // maskable sources
	localparam int           CIA_VEC_W      = 16;       // program counter width
	localparam int           CIA_IDX_W      = 5;        // source index width
	localparam logic [7:0]   CIA_PSW_RST    = 8'h02;    // status word at reset
	localparam int           CIA_PSW_IE_BIT = 7;        // master_enable position
	localparam int           CIA_PSW_ISP_BIT= 1;        // in_service_priority
	localparam logic [15:0]  CIA_BRK_VEC    = 16'h003e; // break vector low word
	localparam int           CIA_LAT_MIN_HI = 7;        // clocks, priority 0
	localparam int           CIA_LAT_MIN_LO = 8;        // clocks, priority 1
	localparam int           CIA_LAT_MAX_HI = 32;       // clocks, priority 0
	localparam int           CIA_LAT_MAX_LO = 33;       // clocks, priority 1
	localparam int           CIA_CNT_W      = 6;        // latency counter width
	// acknowledge sequencer phases
	typedef enum logic [2:0] {
		CIA_IDLE,
		CIA_PUSH_PSW,
		CIA_PUSH_PC,
		CIA_VECTOR,
		CIA_RET_PC,
		CIA_RET_PSW
	} cia_state_t;
endpackage : cia_pkg

// ===== cia_vec_rom.sv
// Purpose: vector table lookup with a registered read
// Assumes: vectors are two-byte entries below the break vector
// Notes:   contents are fixed at synthesis; source n sits at 0004h plus 2n
`timescale 1ns/1ps
module cia_vec_rom #(
	parameter int IDX_W = 5,
	parameter int VEC_W = 16
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// lookup
	input  wire logic [IDX_W-1:0] idx,
	output logic      [VEC_W-1:0] vec
);
	localparam logic [VEC_W-1:0] VEC_BASE = 'h4; // first maskable vector
	// registered read of the table entry
	always_ff @(posedge core_clk) begin
		if (rst) begin
			vec <= '0;
		end else begin
			vec <= VEC_BASE + VEC_W'({idx, 1'b0});
		end
	end
endmodule : cia_vec_rom

// ===== cia_ack.sv
// Purpose: maskable and break interrupt acknowledge, nesting and return
// Assumes: sequencer pulses instr_done at each instruction boundary
// Notes:   sources are synchronous to core_clk; index 0 ranks highest
// Contract
// R1 - eligible means request set, mask clear
// R2 - take vectored request only when enabled
// R3 - refuse low level during high service
// R4 - latency seven to thirtytwo or thirtythree clocks
// R5 - lower level needs at least eight clocks
// R6 - divide completes before servicing begins
// R7 - higher programmed level wins first
// R8 - equal level: fixed default order decides
// R9 - blocked requests stay pending until acknowledgeable
// R10 - push status, pc; clear enable; vector; code pushes only the pc high byte
// R11 - return_from_interrupt restores pc and status; code pops only the pc high byte, low byte from the current pc_save
// R12 - break_trap always taken
// R13 - break pushes, clears enable, vectors 003eh
// R14 - software leaves break only by return_from_break; code clears break on either return
// R15 - software re-enables with enable_interrupts_op
// R16 - nest equal or higher level only
// R17 - nesting needs enable; lower needs isp one
// R18 - one main instruction after return first
// R19 - hold instructions defer acknowledge one instruction
// R20 - break not a hold; clears enable
// R21 - request flag independent of priority flag
// R22 - priority zero high; isp zero high service
// R23 - status word resets to 02h
// R24 - masks and priorities reset to all ones
// R25 - default ranking fixed at synthesis
`timescale 1ns/1ps
module cia_ack
	import cia_pkg::*;
#(
	parameter int SRC_N = cia_pkg::CIA_SRC_N
) (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// peripheral request pulses
	input  wire logic [SRC_N-1:0]         src_event,
	// software flag writes
	input  wire logic                     flag_wr,
	input  wire logic [SRC_N-1:0]         request_wdata,
	input  wire logic                     mask_wr,
	input  wire logic [SRC_N-1:0]         mask_wdata,
	input  wire logic                     prio_wr,
	input  wire logic [SRC_N-1:0]         prio_wdata,
	input  wire logic                     psw_wr,
	input  wire logic [7:0]               psw_wdata,
	// sequencer side
	input  wire logic                     instr_done,
	input  wire logic                     instr_hold,
	input  wire logic                     instr_div,
	input  wire logic                     op_ei,
	input  wire logic                     op_di,
	input  wire logic                     op_brk,
	input  wire logic                     op_return_from_interrupt,
	input  wire logic                     op_return_from_break,
	input  wire logic [cia_pkg::CIA_VEC_W-1:0] pc_in,
	input  wire logic [7:0]               pop_data,
	// outputs to sequencer and stack
	output logic                          seq_stall,
	output logic                          push_en,
	output logic                          pop_en,
	output logic [7:0]                    push_data,
	output logic                          pc_load,
	output logic [cia_pkg::CIA_VEC_W-1:0] pc_out,
	output logic [7:0]                    psw_out,
	output logic [SRC_N-1:0]              request_flag,
	output logic [SRC_N-1:0]              mask_flag,
	output logic [SRC_N-1:0]              priority_flag,
	output logic                          in_break
);
	import cia_pkg::*;

	// all state of the block
	typedef struct packed {
		cia_state_t           st;          // sequencer phase
		logic [SRC_N-1:0]     req;         // request flags
		logic [SRC_N-1:0]     msk;         // mask flags
		logic [SRC_N-1:0]     pri;         // priority flags
		logic [7:0]           processor_status_word;         // status word
		logic                 brk_srv;     // break routine active
		logic                 is_brk;      // current sequence is break
		logic                 is_ret;      // current sequence is return
		logic                 hold;        // defer one more instruction
		logic                 after_ret;   // one main instruction owed
		logic [CIA_IDX_W-1:0] idx;         // taken source
		logic [CIA_VEC_W-1:0] pc_save;     // pc at boundary, high byte to stack
		logic [7:0]           pc_hi;       // popped pc high byte
		logic                 stall;       // sequencer stall
		logic                 push;        // stack push strobe
		logic                 pop;         // stack pop strobe
		logic [7:0]           pdat;        // stack push byte
		logic                 pcl;         // pc load strobe
		logic [CIA_VEC_W-1:0] pco;         // pc load value
		logic [CIA_CNT_W-1:0] age;         // clocks since newest event
	} cia_s_t;

	cia_s_t               s_reg;          // registered state
	cia_s_t               s_next;         // next state
	logic [CIA_VEC_W-1:0] vec_rd;         // table entry of idx
	logic [SRC_N-1:0]     elig;           // acknowledgeable sources
	logic                 win_ok;         // a winner exists
	logic [CIA_IDX_W-1:0] win_idx;        // winning source
	logic                 ie;             // master_enable
	logic                 in_service_priority;            // in_service_priority
	logic                 age_ok;         // request old enough to take
	localparam int LAT_PAD = 4; // take edge plus three sequence edges
	localparam logic [CIA_CNT_W-1:0] AGE_HI =
		CIA_CNT_W'(CIA_LAT_MIN_HI - LAT_PAD); // priority 0 floor
	localparam logic [CIA_CNT_W-1:0] AGE_LO =
		CIA_CNT_W'(CIA_LAT_MIN_LO - LAT_PAD); // priority 1 floor

	assign ie  = s_reg.processor_status_word[CIA_PSW_IE_BIT];
	assign in_service_priority = s_reg.processor_status_word[CIA_PSW_ISP_BIT];
	// R4 R5 lower level waits one clock longer than high
	assign age_ok = s_reg.age >= (s_reg.pri[win_idx] ? AGE_LO : AGE_HI);

	// vector lookup
	cia_vec_rom #(.IDX_W(CIA_IDX_W), .VEC_W(CIA_VEC_W)) u_rom (
		.core_clk (core_clk),
		.rst      (rst),
		.idx      (s_reg.idx),
		.vec      (vec_rd)
	);

	// eligibility per source
	genvar g;
	generate
		for (g = 0; g < SRC_N; g++) begin : g_elig
			// R1 request set and mask clear
			// R3 low level refused in high service
			// R17 lower level needs isp or break
			assign elig[g] = s_reg.req[g] && !s_reg.msk[g] &&
				(!s_reg.pri[g] || in_service_priority || s_reg.brk_srv);
		end
	endgenerate

	// winner selection
	always_comb begin
		win_ok  = 1'b0;
		win_idx = '0;
		// R7 high level pass first
		// R8 R25 fixed order, index zero first
		// R22 priority zero is high
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (elig[i] && !s_reg.pri[i]) begin
				win_ok  = 1'b1;
				win_idx = CIA_IDX_W'(i);
			end
		end
		if (!win_ok) begin
			for (int i = SRC_N - 1; i >= 0; i--) begin
				if (elig[i]) begin
					win_ok  = 1'b1;
					win_idx = CIA_IDX_W'(i);
				end
			end
		end
	end

	// next state
	always_comb begin
		s_next      = s_reg;
		s_next.push = 1'b0;
		s_next.pop  = 1'b0;
		s_next.pcl  = 1'b0;
		// R21 events set flags whatever priority
		s_next.req  = s_reg.req | src_event;
		// R4 age since the newest event, saturating
		if (|src_event) begin
			s_next.age = '0;
		end else if (s_reg.age != '1) begin
			s_next.age = s_reg.age + 1'b1;
		end
		// software writes; a same-cycle event still sets
		if (flag_wr) begin
			s_next.req = request_wdata | src_event;
		end
		if (mask_wr) begin
			s_next.msk = mask_wdata;
		end
		if (prio_wr) begin
			s_next.pri = prio_wdata;
		end
		if (psw_wr) begin
			s_next.processor_status_word = psw_wdata;
		end
		unique case (s_reg.st)
			// watch instruction boundaries
			CIA_IDLE: begin
				s_next.stall = 1'b0;
				if (instr_done) begin
					if (op_ei) begin
						s_next.processor_status_word[CIA_PSW_IE_BIT] = 1'b1;
					end
					if (op_di) begin
						s_next.processor_status_word[CIA_PSW_IE_BIT] = 1'b0;
					end
					// R19 hold defers one instruction
					s_next.hold      = instr_hold;
					s_next.after_ret = 1'b0;
					s_next.pc_save   = pc_in;
					if (op_brk) begin
						// R12 R20 break always, no hold
						s_next.st     = CIA_PUSH_PSW;
						s_next.is_brk = 1'b1;
						s_next.is_ret = 1'b0;
						s_next.stall  = 1'b1;
					end else if (op_return_from_interrupt || op_return_from_break) begin
						// R11 return pops pc then status
						s_next.st     = CIA_RET_PC;
						s_next.is_ret = 1'b1;
						s_next.stall  = 1'b1;
						s_next.pop    = 1'b1;
					// R2 R9 R16 R18 enabled, pending
					// R6 divide ends first at boundary
					end else if (ie && win_ok && age_ok && !s_reg.hold &&
							!s_reg.after_ret && !instr_hold) begin
						s_next.st     = CIA_PUSH_PSW;
						s_next.is_brk = 1'b0;
						s_next.is_ret = 1'b0;
						s_next.idx    = win_idx;
						s_next.stall  = 1'b1;
					end
				end
			end
			// R10 R13 push status first
			CIA_PUSH_PSW: begin
				s_next.push = 1'b1;
				s_next.pdat = s_reg.processor_status_word;
				s_next.st   = CIA_PUSH_PC;
				s_next.processor_status_word[CIA_PSW_IE_BIT] = 1'b0;
				if (s_reg.is_brk) begin
					s_next.brk_srv = 1'b1;
				end else begin
					s_next.processor_status_word[CIA_PSW_ISP_BIT] = s_reg.pri[s_reg.idx];
					s_next.req[s_reg.idx] = src_event[s_reg.idx];
				end
			end
			// then the pc high byte only; the low byte stays in pc_save
			CIA_PUSH_PC: begin
				s_next.push = 1'b1;
				s_next.pdat = s_reg.pc_save[15:8];
				s_next.st   = CIA_VECTOR;
			end
			// R13 load vector
			CIA_VECTOR: begin
				s_next.pcl   = 1'b1;
				s_next.pco   = s_reg.is_brk ? CIA_BRK_VEC : vec_rd;
				s_next.st    = CIA_IDLE;
				s_next.stall = 1'b0;
			end
			// popped pc high byte
			CIA_RET_PC: begin
				s_next.pc_hi = pop_data;
				s_next.pop   = 1'b1;
				s_next.st    = CIA_RET_PSW;
			end
			// R11 R18 restore status, owe one instruction
			CIA_RET_PSW: begin
				s_next.processor_status_word       = pop_data;
				s_next.pcl       = 1'b1;
				s_next.pco       = {s_reg.pc_hi, s_reg.pc_save[7:0]};
				s_next.brk_srv   = 1'b0;
				s_next.after_ret = 1'b1;
				s_next.st        = CIA_IDLE;
				s_next.stall     = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg     <= '0;
			s_reg.st  <= CIA_IDLE;
			// R23 status word reset value
			s_reg.processor_status_word <= CIA_PSW_RST;
			// R24 all masked, lower level
			s_reg.msk <= '1;
			s_reg.pri <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	assign seq_stall     = s_reg.stall;
	assign push_en       = s_reg.push;
	assign pop_en        = s_reg.pop;
	assign push_data     = s_reg.pdat;
	assign pc_load       = s_reg.pcl;
	assign pc_out        = s_reg.pco;
	assign psw_out       = s_reg.processor_status_word;
	assign request_flag  = s_reg.req;
	assign mask_flag     = s_reg.msk;
	assign priority_flag = s_reg.pri;
	assign in_break      = s_reg.brk_srv;

	// assertions
	property p_ie_clr; // R10
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_PUSH_PSW) |=> !psw_out[CIA_PSW_IE_BIT];
	endproperty
	a_ie_clr: assert property (p_ie_clr) else $error("enable not cleared");

	property p_seq_len; // R4
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_PUSH_PSW) |=> ##1 (s_reg.st == CIA_VECTOR) ##1 pc_load;
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("bad sequence length");

	property p_brk_vec; // R13
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_VECTOR && s_reg.is_brk) |=> pc_out == CIA_BRK_VEC;
	endproperty
	a_brk_vec: assert property (p_brk_vec) else $error("break vector wrong");

	property p_no_take_di; // R2
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_IDLE && !op_brk && !ie) |=> s_reg.st != CIA_PUSH_PSW;
	endproperty
	a_no_take_di: assert property (p_no_take_di) else $error("taken disabled");

	property p_isp_copy; // R10
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_PUSH_PSW && !s_reg.is_brk) |=>
			psw_out[CIA_PSW_ISP_BIT] == $past(s_reg.pri[s_reg.idx]);
	endproperty
	a_isp_copy: assert property (p_isp_copy) else $error("isp not copied");

	property p_after_ret; // R18
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_IDLE && s_reg.after_ret && !op_brk) |=>
			s_reg.st != CIA_PUSH_PSW;
	endproperty
	a_after_ret: assert property (p_after_ret) else $error("no main instr");

	property p_hold; // R19
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_IDLE && instr_done && instr_hold && !op_brk) |=>
			s_reg.st != CIA_PUSH_PSW;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not honoured");

	property p_event_set; // R21
		@(posedge core_clk) disable iff (rst)
		src_event[0] |=> request_flag[0];
	endproperty
	a_event_set: assert property (p_event_set) else $error("event lost");

	property p_brk_take; // R12
		@(posedge core_clk) disable iff (rst)
		(s_reg.st == CIA_IDLE && instr_done && op_brk) |=>
			s_reg.st == CIA_PUSH_PSW;
	endproperty
	a_brk_take: assert property (p_brk_take) else $error("break not taken");

	c_mask_take: cover property (@(posedge core_clk)
		s_reg.st == CIA_PUSH_PSW && !s_reg.is_brk);
	c_brk: cover property (@(posedge core_clk) s_reg.is_brk && pc_load);
	c_ret: cover property (@(posedge core_clk) s_reg.st == CIA_RET_PSW);
	c_nest: cover property (@(posedge core_clk)
		s_reg.st == CIA_PUSH_PSW && s_reg.brk_srv);
endmodule : cia_ack

// ===== cia_seq_model.sv
// Purpose: behavioural instruction sequencer and stack facing the block
// Assumes: one instruction every four clocks, held off while stalled
// Notes:   stack top shows ahead while stalled, else its inverse
`timescale 1ns/1ps
module cia_seq_model
	import cia_pkg::*;
(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// block outputs
	input  wire logic                 seq_stall,
	input  wire logic                 push_en,
	input  wire logic                 pop_en,
	input  wire logic [7:0]           push_data,
	// bench command: {return_from_break, return_from_interrupt, brk, di, ei}
	input  wire logic [4:0]           op_sel,
	// sequencer outputs
	output logic                      instr_done,
	output logic                      instr_hold,
	output logic                      op_ei,
	output logic                      op_di,
	output logic                      op_brk,
	output logic                      op_return_from_interrupt,
	output logic                      op_return_from_break,
	output logic [cia_pkg::CIA_VEC_W-1:0] pc_in,
	output logic [7:0]                pop_data
);
	logic [1:0] cnt_reg;   // instruction pacing
	logic [7:0] stk[$];    // stack memory
	logic [7:0] top_reg;   // byte on top of the stack
	// stack byte shows only while the block is stalled
	assign pop_data = seq_stall ? top_reg : ~top_reg;
	// commands ride only on the boundary pulse
	// re-enable, break exit
	assign op_ei   = op_sel[0] & instr_done;
	assign op_di   = op_sel[1] & instr_done;
	assign op_brk  = op_sel[2] & instr_done;
	assign op_return_from_interrupt = op_sel[3] & instr_done;
	assign op_return_from_break = op_sel[4] & instr_done;
	assign instr_hold = instr_done & (|{op_sel[4:3], op_sel[1:0]});
	// pacing, pc advance and the stack
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_reg    <= 2'h0;
			instr_done <= 1'b0;
			pc_in      <= 16'h0100;
			top_reg    <= 8'h00;
			stk.delete();
		end else begin
			cnt_reg    <= cnt_reg + 2'h1;
			instr_done <= (cnt_reg == 2'h3) && !seq_stall;
			if (instr_done)
				pc_in <= pc_in + 16'h0002;
			// top byte is shown ahead, a pop moves to the next one
			if (push_en) begin
				stk.push_back(push_data);
				top_reg <= push_data;
			end else if (pop_en && stk.size() > 0) begin
				void'(stk.pop_back());
				top_reg <= (stk.size() > 0) ? stk[$] : 8'h00;
			end
		end
	end
endmodule : cia_seq_model

// ===== tb.sv
// Purpose: self-checking bench for the interrupt acknowledge block
// Assumes: sequencer model paces instructions; flag writes unused
// Notes:   expectations come from the package constants, the bench vec table and literal status words
`timescale 1ns/1ps
module tb;
	import cia_pkg::*;
	localparam int N = CIA_SRC_N;
	logic core_clk = 0, rst = 1, mask_wr = 0, prio_wr = 0, psw_wr = 0;
	logic [N-1:0] src_event = '0, mask_wdata = '0, prio_wdata = '0;
	logic [7:0] psw_wdata = 8'h00, push_data, psw_out, pop_data;
	logic [4:0] op_sel = 5'h00;
	logic instr_done, instr_hold, op_ei, op_di, op_brk, op_return_from_interrupt, op_return_from_break;
	logic seq_stall, push_en, pop_en, pc_load, in_break;
	logic [15:0] pc_in, pc_out;
	logic [N-1:0] request_flag, mask_flag, priority_flag, m, p, ev;
	int n_mismatch = 0, checks = 0, cyc = 0, a, b, w, lat;
	always #20 core_clk = ~core_clk;
	cia_ack #(.SRC_N(N)) dut (.core_clk(core_clk), .rst(rst),
		.src_event(src_event), .flag_wr(1'b0), .request_wdata('0),
		.mask_wr(mask_wr), .mask_wdata(mask_wdata), .prio_wr(prio_wr),
		.prio_wdata(prio_wdata), .psw_wr(psw_wr), .psw_wdata(psw_wdata),
		.instr_done(instr_done), .instr_hold(instr_hold),
		.instr_div(1'b0), .op_ei(op_ei), .op_di(op_di), .op_brk(op_brk),
		.op_return_from_interrupt(op_return_from_interrupt), .op_return_from_break(op_return_from_break), .pc_in(pc_in),
		.pop_data(pop_data), .seq_stall(seq_stall), .push_en(push_en),
		.pop_en(pop_en), .push_data(push_data), .pc_load(pc_load),
		.pc_out(pc_out), .psw_out(psw_out), .request_flag(request_flag),
		.mask_flag(mask_flag), .priority_flag(priority_flag),
		.in_break(in_break));
	cia_seq_model seq (.core_clk(core_clk), .rst(rst),
		.seq_stall(seq_stall), .push_en(push_en), .pop_en(pop_en),
		.push_data(push_data), .op_sel(op_sel), .instr_done(instr_done),
		.instr_hold(instr_hold), .op_ei(op_ei), .op_di(op_di),
		.op_brk(op_brk), .op_return_from_interrupt(op_return_from_interrupt), .op_return_from_break(op_return_from_break),
		.pc_in(pc_in), .pop_data(pop_data));
	// value comparison with counting
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	function automatic logic [15:0] vec(input int i);
		return 16'h0004 + 16'(2 * i);
	endfunction : vec
	// wait for a pc load, vector or return, bounded
	task automatic await_load(input int lim, output int l);
		l = 0;
		do begin
			tick();
			l++;
		end while (pc_load !== 1'b1 && l < lim);
	endtask : await_load
	// hold a command until the boundary samples it
	task automatic do_op(input logic [4:0] s);
		int k;
		k = 0;
		op_sel = s;
		while (instr_done !== 1'b1 && k < 40) begin
			tick();
			k++;
		end
		tick();
		op_sel = 5'h00;
	endtask : do_op
	task automatic cfg(input logic [N-1:0] mk, pr, input logic [7:0] s);
		{mask_wr, prio_wr, psw_wr} = 3'h7;
		{mask_wdata, prio_wdata, psw_wdata} = {mk, pr, s};
		tick();
		{mask_wr, prio_wr, psw_wr} = 3'h0;
	endtask : cfg
	// raise events and check the acknowledge that follows
	task automatic take(input logic [N-1:0] e, input int x, input logic pr);
		int l;
		src_event = e;
		tick();
		src_event = '0;
		await_load(60, l);
		cmp(pc_out, vec(x));
		cmp(psw_out[CIA_PSW_ISP_BIT], pr);
		cmp(psw_out[CIA_PSW_IE_BIT], 0);
		cmp(l >= (pr ? CIA_LAT_MIN_LO : CIA_LAT_MIN_HI), 1);
		cmp(l <= (pr ? CIA_LAT_MAX_LO : CIA_LAT_MAX_HI), 1);
	endtask : take
	task automatic ret_chk(input logic [7:0] s);
		int l;
		do_op(5'h08);
		await_load(20, l);
		cmp(psw_out, s);
	endtask : ret_chk
	task automatic quiet();
		int l;
		await_load(40, l);
		cmp(pc_load, 0);
	endtask : quiet
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// cycle ceiling against hangs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(32'hf2fe7ccf));
		repeat (8) tick();
		rst = 0;
		cmp(psw_out, CIA_PSW_RST);
		cmp(mask_flag, {N{1'b1}});
		cmp(priority_flag, {N{1'b1}});
		cmp(request_flag, '0);
		// simultaneous pairs, first one at equal level
		for (int i = 0; i < 6; i++) begin
			a = $urandom_range(N - 1);
			b = (a + 1 + $urandom_range(N - 2)) % N;
			p = N'($urandom);
			if (i == 0)
				p[a] = p[b];
			m = '1;
			m[a] = 1'b0;
			m[b] = 1'b0;
			cfg(m, p, 8'h82);
			w = (p[a] != p[b]) ? (p[a] ? b : a) : (a < b ? a : b);
			ev = '0;
			ev[a] = 1'b1;
			ev[b] = 1'b1;
			take(ev, w, p[w]);
			ret_chk(8'h82);
			await_load(60, lat);
			cmp(pc_out, vec(a + b - w));
			ret_chk(8'h82);
		end
		// masked, then disabled, then enabled
		cfg('1, '0, 8'h82);
		src_event[3] = 1'b1;
		tick();
		src_event = '0;
		quiet();
		cmp(request_flag[3], 1);
		cfg(~(N'(1) << 3), '0, 8'h02);
		quiet();
		do_op(5'h01);
		await_load(60, lat);
		cmp(pc_out, vec(3));
		ret_chk(8'h82);
		// low level refused under high service, equal level nests
		cfg(~(N'(7)), N'(4), 8'h82);
		take(N'(2), 1, 1'b0);
		do_op(5'h01);
		src_event[2] = 1'b1;
		tick();
		src_event = '0;
		quiet();
		take(N'(1), 0, 1'b0);
		ret_chk(8'h80);
		quiet();
		ret_chk(8'h82);
		await_load(60, lat);
		cmp(pc_out, vec(2));
		ret_chk(8'h82);
		// break taken while disabled
		cfg('1, '1, 8'h02);
		do_op(5'h04);
		await_load(20, lat);
		cmp(pc_out, CIA_BRK_VEC);
		cmp(in_break, 1);
		cmp(psw_out[CIA_PSW_IE_BIT], 0);
		do_op(5'h10);
		await_load(20, lat);
		cmp(psw_out, 8'h02);
		cmp(in_break, 0);
		wrap_up();
	end
endmodule : tb
